// *** verilog/rtc_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 20 MHz system clock, 32.768 kHz timekeeping oscillator.
// Notes:   Definitions only; included by its bare name.
//
// How it works
// R1 - Four or more missed oscillator pulses latch the fail flag to one.
// R2 - Power-up forces the fail flag to one regardless of the oscillator.
// R3 - Host clears the fail flag by a serial write; stays clear until failure.
// R4 - Flag reads zero without failure, one after four missed pulses.
// R5 - Minute register at 0x01: flag bit 7, tens 6:4, units 3:0.
// R6 - Tens-of-minutes digit is BCD, valid zero through five.
// R7 - Units-of-minutes digit is BCD, valid zero through nine.
// R8 - Invalid tens digit keeps counting until rollover, then stays valid.
// R9 - Invalid units digit keeps counting until rollover, then stays valid.
// R10 - After backup-to-main switch, time may be stale up to one second.
// R11 - Hour register at 0x02: enable 7, century 6, tens 5:4, units 3:0.
// R12 - Century bit tracked when enable is one, ignored when zero.
// R13 - With tracking on, century bit inverts on year wrap 99 to 00.
// R14 - Hour digits count BCD in 24-hour format.
// R15 - Minutes step per seconds rollover, wrap 59 to 00, carry hours.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define MIN_REG_ADDR   8'h01
`define HOUR_REG_ADDR  8'h02
`define MIN_RESET      8'h80
`define HOUR_RESET     8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ     20000000
`define OSC_FREQ_HZ     32768
`define OSC_MISS_PULSES 4
`define MISS_CYCLES ((`OSC_MISS_PULSES * `CLK_FREQ_HZ + `OSC_FREQ_HZ - 1) \
                     / `OSC_FREQ_HZ)
`define REFRESH_TIME_S  1
`define SECS_PER_MIN    60

`endif

// *** verilog/rtc_pkg.sv ***
// Purpose: Shared types of the minute counter block.
// Assumes: Constants live in rtc_regs.svh.
// Notes:   Types only.
`default_nettype none
package rtc_pkg;

    // ------------------------------------------------------------------
    // Serial slave states and byte roles
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_RX    = 3'b001,
        S_ACK   = 3'b010,
        S_TX    = 3'b011,
        S_TXACK = 3'b100
    } i2c_state_t;

    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_PTR  = 2'b01,
        K_DATA = 2'b10
    } byte_kind_t;

    // ------------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       osc_fail_flag;
        logic [2:0] minute_tens;
        logic [3:0] minute_units;
    } minute_reg_t;

    typedef struct packed {
        logic       century_track_enable;
        logic       century_toggle_bit;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
    } hour_reg_t;

    // Pin samples and events crossing from the oscillator domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic main;
    } pin_bits_t;

    typedef struct packed {
        logic min_tog;
        logic beat_tog;
    } osc_events_t;

endpackage
`default_nettype wire

// *** verilog/rtc_osc_events.sv ***
// Purpose: Oscillator-domain prescaler emitting minute and beat toggles.
// Assumes: osc_clk_i is the timekeeping oscillator.
// Notes:   Toggles, not pulses, so the fast side never misses an event.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_osc_events
    import rtc_pkg::*;
#(
    parameter int unsigned TICKS_PER_MIN = `OSC_FREQ_HZ * `SECS_PER_MIN,
    parameter int unsigned DIV_W         = 21
) (
    // Oscillator clock and reset
    input  wire logic  osc_clk_i,
    input  wire logic  rst_n_i,
    // Toggles toward the system domain
    output var osc_events_t events_o
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
        osc_events_t      ev;
    } osc_state_t;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICKS_PER_MIN - 1);

    osc_state_t q;
    osc_state_t n;

    // Beat flips every edge; minute flips once per seconds rollover
    always_comb begin
        n = q;
        n.ev.beat_tog = ~q.ev.beat_tog;
        if (q.div == DIV_LAST) begin
            n.div        = '0;
            n.ev.min_tog = ~q.ev.min_tog; // R15
        end else begin
            n.div = q.div + DIV_W'(1);
        end
    end

    always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign events_o = q.ev;

endmodule
`default_nettype wire

// *** verilog/rtc_minutes_osc_fail.sv ***
// Purpose: Minute and hour registers with oscillator-fail latch, I2C slave.
// Assumes: Host is an I2C controller; SCL and SDA are oversampled.
// Notes:   Oscillator beat must be slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module rtc_minutes_osc_fail
    import rtc_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR       = 7'h5a, // Arbitrary value
    parameter int unsigned REFRESH_CYCLES = `REFRESH_TIME_S * `CLK_FREQ_HZ,
    parameter int unsigned TICKS_PER_MIN  = `OSC_FREQ_HZ * `SECS_PER_MIN
) (
    // System clock and reset
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    // Oscillator domain
    input  wire logic osc_clk_i,
    // Serial pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_n_o,
    // Supply, calendar and oscillator fail
    input  wire logic supply_main_i,
    input  wire logic year_wrap_i,
    output logic      day_carry_o,
    output logic      time_stale_o,
    output logic      osc_fail_o
);

    // ------------------------------------------------------------------
    // Constants and state
    // ------------------------------------------------------------------
    localparam int unsigned MISS_W  = 12;
    localparam int unsigned STALE_W = 25;
    localparam logic [MISS_W-1:0] MISS_LAST = MISS_W'(`MISS_CYCLES - 1);
    localparam logic [STALE_W-1:0] STALE_LOAD = STALE_W'(REFRESH_CYCLES);

    typedef struct packed {
        pin_bits_t          pin_s1;
        pin_bits_t          pin_s2;
        pin_bits_t          pin_p;
        osc_events_t        ev_s1;
        osc_events_t        ev_s2;
        osc_events_t        ev_p;
        i2c_state_t         state;
        byte_kind_t         kind;
        logic [3:0]         bit_cnt;
        logic [7:0]         shift;
        logic [7:0]         ptr;
        logic               read_mode;
        logic               nack;
        logic               sda_out;
        logic               sda_oe_n;
        minute_reg_t        minute;
        hour_reg_t          hour;
        logic [MISS_W-1:0]  miss;
        logic [STALE_W-1:0] stale_cnt;
        logic               stale;
        logic               day_carry;
    } state_t;

    // Pin stages start at the bus idle level, so no false edge after reset
    localparam state_t RESET_STATE = '{
        pin_s1:   '{scl: 1'b1, sda: 1'b1, main: 1'b0},
        pin_s2:   '{scl: 1'b1, sda: 1'b1, main: 1'b0},
        pin_p:    '{scl: 1'b1, sda: 1'b1, main: 1'b0},
        state:    S_IDLE,
        kind:     K_ADDR,
        sda_oe_n: 1'b1,
        minute:   minute_reg_t'(`MIN_RESET),
        hour:     hour_reg_t'(`HOUR_RESET),
        default:  '0
    };

    state_t      q;
    state_t      n;
    osc_events_t osc_ev;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // BCD step: roll at the last valid digit or at the field maximum,
    // so an invalid digit keeps counting until its field wraps
    function automatic logic [4:0] bcd_step(input logic [3:0] d,
                                            input logic [3:0] last,
                                            input logic [3:0] fmax);
        logic [4:0] r;
        if (d == last || d == fmax) begin
            r = 5'h10;
        end else begin
            r = {1'b0, d + 4'h1};
        end
        return r;
    endfunction

    // Read decode; unmapped pointers read zero
    function automatic logic [7:0] read_byte(input logic [7:0] a,
                                             input minute_reg_t m,
                                             input hour_reg_t h);
        logic [7:0] r;
        r = 8'h00;
        if (a == `MIN_REG_ADDR) begin
            r = m;
        end else if (a == `HOUR_REG_ADDR) begin
            r = h;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Oscillator domain
    // ------------------------------------------------------------------
    rtc_osc_events #(
        .TICKS_PER_MIN (TICKS_PER_MIN),
        .DIV_W         (21)
    ) rtc_osc_events_inst (
        .osc_clk_i (osc_clk_i),
        .rst_n_i   (rst_n_i),
        .events_o  (osc_ev)
    );

    // ------------------------------------------------------------------
    // Edge and strobe decode
    // ------------------------------------------------------------------
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       main_rise;
    logic       min_tick;
    logic       beat_edge;
    logic       fail_evt;
    logic       wr_en;
    logic       wr_min;
    logic       wr_hour;
    logic       hour_tick;
    logic [4:0] su;
    logic [4:0] st;
    logic [4:0] hu;
    logic [4:0] ht;
    logic [7:0] rb;

    // Only second stages and their delayed copies are looked at
    assign scl_rise  = q.pin_s2.scl & ~q.pin_p.scl;
    assign scl_fall  = ~q.pin_s2.scl & q.pin_p.scl;
    assign bus_start = q.pin_s2.scl & q.pin_p.scl
                     & q.pin_p.sda & ~q.pin_s2.sda;
    assign bus_stop  = q.pin_s2.scl & q.pin_p.scl
                     & ~q.pin_p.sda & q.pin_s2.sda;
    assign main_rise = q.pin_s2.main & ~q.pin_p.main;
    assign min_tick  = q.ev_s2.min_tog ^ q.ev_p.min_tog;
    assign beat_edge = q.ev_s2.beat_tog ^ q.ev_p.beat_tog;
    // Holds while the silence lasts four oscillator periods or more
    assign fail_evt  = ~beat_edge & (q.miss == MISS_LAST); // R1
    assign wr_en     = (q.state == S_RX) & scl_fall
                     & (q.bit_cnt == 4'h8) & (q.kind == K_DATA);
    assign wr_min    = wr_en & (q.ptr == `MIN_REG_ADDR); // R5
    assign wr_hour   = wr_en & (q.ptr == `HOUR_REG_ADDR); // R11

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = q;
        su = 5'h00;
        st = 5'h00;
        hu = 5'h00;
        ht = 5'h00;
        hour_tick = 1'b0;
        rb = read_byte(q.ptr, q.minute, q.hour);
        n.pin_s1 = '{scl: scl_i, sda: sda_i, main: supply_main_i};
        n.pin_s2 = q.pin_s1;
        n.pin_p  = q.pin_s2;
        n.ev_s1  = osc_ev;
        n.ev_s2  = q.ev_s1;
        n.ev_p   = q.ev_s2;
        n.sda_out = 1'b0;
        n.day_carry = 1'b0;

        // Serial slave: address, pointer, then data with auto-increment
        unique case (q.state)
            S_IDLE: begin
                n.sda_oe_n = 1'b1;
            end
            S_RX: begin
                if (scl_rise) begin
                    n.shift   = {q.shift[6:0], q.pin_s2.sda};
                    n.bit_cnt = q.bit_cnt + 4'h1;
                end else if (scl_fall && q.bit_cnt == 4'h8) begin
                    n.bit_cnt  = 4'h0;
                    n.state    = S_ACK;
                    n.sda_oe_n = 1'b0;
                    unique case (q.kind)
                        K_ADDR: begin
                            if (q.shift[7:1] != DEV_ADDR) begin
                                n.state    = S_IDLE;
                                n.sda_oe_n = 1'b1;
                            end
                            n.read_mode = q.shift[0];
                        end
                        K_PTR: n.ptr = q.shift;
                        default: n.ptr = q.ptr + 8'h01;
                    endcase
                end
            end
            S_ACK: begin
                if (scl_fall) begin
                    if (q.kind == K_ADDR && q.read_mode) begin
                        n.ptr      = q.ptr + 8'h01;
                        n.sda_oe_n = rb[7];
                        n.shift    = {rb[6:0], 1'b0};
                        n.state    = S_TX;
                    end else begin
                        n.sda_oe_n = 1'b1;
                        n.state    = S_RX;
                        n.kind = (q.kind == K_ADDR) ? K_PTR : K_DATA;
                    end
                end
            end
            S_TX: begin
                if (scl_rise) begin
                    n.bit_cnt = q.bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (q.bit_cnt == 4'h8) begin
                        n.sda_oe_n = 1'b1;
                        n.state    = S_TXACK;
                    end else begin
                        n.sda_oe_n = q.shift[7];
                        n.shift    = {q.shift[6:0], 1'b0};
                    end
                end
            end
            S_TXACK: begin
                if (scl_rise) begin
                    n.nack = q.pin_s2.sda;
                end else if (scl_fall) begin
                    n.bit_cnt = 4'h0;
                    if (q.nack) begin
                        n.state = S_IDLE;
                    end else begin
                        n.ptr      = q.ptr + 8'h01;
                        n.sda_oe_n = rb[7];
                        n.shift    = {rb[6:0], 1'b0};
                        n.state    = S_TX;
                    end
                end
            end
            default: begin
                n.state    = S_IDLE;
                n.sda_oe_n = 1'b1;
            end
        endcase

        // Start and stop override any state, even mid-byte
        if (bus_start) begin
            n.state    = S_RX;
            n.kind     = K_ADDR;
            n.bit_cnt  = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            n.state    = S_IDLE;
            n.sda_oe_n = 1'b1;
        end

        // Minute count, carry into hours
        if (min_tick) begin
            su = bcd_step(q.minute.minute_units, 4'h9, 4'hf); // R7 R9
            n.minute.minute_units = su[3:0];
            if (su[4]) begin
                st = bcd_step({1'b0, q.minute.minute_tens},
                              4'h5, 4'h7); // R6 R8
                n.minute.minute_tens = st[2:0];
                hour_tick = st[4]; // R15
            end
        end

        // Hour count in 24-hour BCD
        if (hour_tick) begin
            if (q.hour.hour_tens == 2'h2 && q.hour.hour_units == 4'h3) begin
                n.hour.hour_tens  = 2'h0; // R14
                n.hour.hour_units = 4'h0;
                n.day_carry       = 1'b1;
            end else begin
                hu = bcd_step(q.hour.hour_units, 4'h9, 4'hf);
                n.hour.hour_units = hu[3:0];
                if (hu[4]) begin
                    ht = bcd_step({2'b00, q.hour.hour_tens}, 4'h2, 4'h3);
                    n.hour.hour_tens = ht[1:0];
                    n.day_carry      = ht[4];
                end
            end
        end

        // Century bit follows the year wrap only when tracking is on
        if (year_wrap_i && q.hour.century_track_enable) begin
            n.hour.century_toggle_bit = ~q.hour.century_toggle_bit; // R12 R13
        end

        // Host writes take priority over counting
        if (wr_min) begin
            n.minute = minute_reg_t'(q.shift); // R3
        end
        if (wr_hour) begin
            n.hour = hour_reg_t'(q.shift);
        end

        // Failure detector; a set beats a same-cycle clear
        if (beat_edge) begin
            n.miss = '0;
        end else if (q.miss != MISS_LAST) begin
            n.miss = q.miss + MISS_W'(1);
        end
        if (fail_evt) begin
            n.minute.osc_fail_flag = 1'b1; // R1 R4
        end

        // Stale window after switching to the main supply
        if (main_rise) begin
            n.stale_cnt = STALE_LOAD; // R10
            n.stale     = 1'b1;
        end else if (q.stale_cnt != '0) begin
            n.stale_cnt = q.stale_cnt - STALE_W'(1);
        end else begin
            n.stale = 1'b0;
        end
    end

    // Reset loads the fail flag set, as after first power-up
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RESET_STATE; // R2
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sda_o        = q.sda_out;
    assign sda_oe_n_o   = q.sda_oe_n;
    assign day_carry_o  = q.day_carry;
    assign time_stale_o = q.stale;
    assign osc_fail_o   = q.minute.osc_fail_flag;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_fail_sets_flag: assert property ( // R1
        fail_evt |=> q.minute.osc_fail_flag && q.miss == MISS_LAST)
        else $error("fail event did not set flag");

    chk_flag_sticky: assert property ( // R4
        q.minute.osc_fail_flag && !wr_min |=> q.minute.osc_fail_flag)
        else $error("fail flag dropped without a write");

    chk_flag_clear: assert property ( // R3
        wr_min && !q.shift[7] && !fail_evt
        |=> !q.minute.osc_fail_flag [*2] or (fail_evt or wr_min))
        else $error("fail flag not cleared by write");

    chk_miss_window: assert property ( // R1
        beat_edge ##1 (!beat_edge [*8]) |-> !fail_evt)
        else $error("fail event too early");

    chk_minute_wrap: assert property ( // R15
        min_tick && !wr_min && q.minute.minute_tens == 3'h5
        && q.minute.minute_units == 4'h9
        |=> q.minute.minute_tens == 3'h0 && q.minute.minute_units == 4'h0)
        else $error("minute did not wrap from 59");

    chk_units_roll: assert property ( // R7
        min_tick && !wr_min && q.minute.minute_units == 4'h9
        |=> q.minute.minute_units == 4'h0)
        else $error("units did not roll at nine");

    chk_units_invalid: assert property ( // R9
        min_tick && !wr_min && q.minute.minute_units == 4'hc
        |=> q.minute.minute_units == 4'hd)
        else $error("invalid units digit not carried");

    chk_tens_invalid: assert property ( // R8
        min_tick && !wr_min && q.minute.minute_units == 4'h9
        && q.minute.minute_tens == 3'h6
        |=> q.minute.minute_tens == 3'h7)
        else $error("invalid tens digit not carried");

    chk_century_toggle: assert property ( // R13
        year_wrap_i && q.hour.century_track_enable && !wr_hour
        |=> q.hour.century_toggle_bit != $past(q.hour.century_toggle_bit))
        else $error("century bit did not invert");

    chk_century_ignored: assert property ( // R12
        year_wrap_i && !q.hour.century_track_enable && !wr_hour
        |=> $stable(q.hour.century_toggle_bit))
        else $error("century bit moved while disabled");

    chk_hour_wrap: assert property ( // R14
        hour_tick && !wr_hour && q.hour.hour_tens == 2'h2
        && q.hour.hour_units == 4'h3
        |=> q.hour.hour_tens == 2'h0 && q.hour.hour_units == 4'h0
        && day_carry_o)
        else $error("hours did not wrap from 23");

    chk_stale_hold: assert property ( // R10
        main_rise |=> time_stale_o [*8])
        else $error("stale window not held");

    cov_minute_write: cover property (wr_min);
    cov_osc_fail:     cover property (fail_evt);
    cov_hour_carry:   cover property (hour_tick);
    cov_read_byte:    cover property (q.state == S_TX && scl_fall);

endmodule
`default_nettype wire

// *** tb/rtc_i2c_host.sv ***
// Purpose: I2C controller model for the minute register block.
// Assumes: Each SCL phase lasts at least six system clocks.
// Notes:   Open drain; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_host #(
    parameter logic [6:0] ADDR = 7'h5a
) (
    // Clock and resolved data wire
    input  wire logic clock_i,
    input  wire logic sda_i,
    // Driven pins
    output var logic  scl_o,
    output var logic  sda_pull_n_o
);
    int nacks = 0;
    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_pull_n_o = 1'b1;
    end
    // Six cycles keeps both phases above the four-cycle minimum
    task automatic wt();
        repeat (6) @(posedge clock_i);
    endtask
    // Data moves one cycle after SCL falls, never while SCL is high
    task automatic put(input logic b);
        @(posedge clock_i);
        sda_pull_n_o <= b;
        wt();
        scl_o <= 1'b1;
        wt();
        scl_o <= 1'b0;
    endtask
    task automatic get(output logic b);
        @(posedge clock_i);
        sda_pull_n_o <= 1'b1;
        wt();
        scl_o <= 1'b1;
        wt();
        b = sda_i;
        scl_o <= 1'b0;
    endtask
    // Start also serves as repeated start
    task automatic start();
        @(posedge clock_i);
        sda_pull_n_o <= 1'b1;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_pull_n_o <= 1'b0;
        wt();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        @(posedge clock_i);
        sda_pull_n_o <= 1'b0;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_pull_n_o <= 1'b1;
        wt();
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(a);
        if (a !== 1'b0) nacks++;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(last);
    endtask
    // Writing bit 7 low is how the host clears the fail flag
    task automatic write_regs(input logic [7:0] ptr, input logic [15:0] d,
                              input int n);
        start();
        wbyte({ADDR, 1'b0});
        wbyte(ptr);
        for (int i = n - 1; i >= 0; i--) wbyte(d[i*8 +: 8]);
        stop();
    endtask
    // Reads the byte at ptr and the next one
    task automatic read_regs(input logic [7:0] ptr, output logic [15:0] d);
        start();
        wbyte({ADDR, 1'b0});
        wbyte(ptr);
        start();
        wbyte({ADDR, 1'b1});
        rbyte(1'b0, d[15:8]);
        rbyte(1'b1, d[7:0]);
        stop();
    endtask
endmodule
`default_nettype wire

// *** tb/rtc_minutes_osc_fail_test.sv ***
// Purpose: Self-checking bench of the minute and hour registers.
// Assumes: Eight oscillator edges make one minute.
// Notes:   Oscillator only runs within bursts, so idle gaps set the flag.
`timescale 1ns/1ps
`default_nettype none
module rtc_minutes_osc_fail_test;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        osc_clk_i = 1'b0;
    logic        supply_main_i = 1'b0;
    logic        year_wrap_i = 1'b0;
    logic        scl, pull_n, sda_o, sda_oe_n, carry, stale, fail;
    logic [15:0] d;
    int          n_errors = 0;
    int          n_checks = 0;
    int          carries = 0;
    wire         sda_w = pull_n & (sda_oe_n | sda_o);
    rtc_minutes_osc_fail #(.REFRESH_CYCLES(20), .TICKS_PER_MIN(8))
    rtc_minutes_osc_fail_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .osc_clk_i(osc_clk_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .supply_main_i(supply_main_i),
        .year_wrap_i(year_wrap_i), .day_carry_o(carry),
        .time_stale_o(stale), .osc_fail_o(fail));
    rtc_i2c_host rtc_i2c_host_inst (.clock_i(clock_i), .sda_i(sda_w),
        .scl_o(scl), .sda_pull_n_o(pull_n));
    // Clock and day carry tally
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        if (carry === 1'b1) carries <= carries + 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic osc(input int n, input int half);
        repeat (n) begin
            #(half) osc_clk_i = 1'b1;
            #(half) osc_clk_i = 1'b0;
        end
    endtask
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_reset();
        check("fail at reset", {7'h00, fail}, 8'h01);
        rtc_i2c_host_inst.read_regs(8'h01, d);
        check("minute reset", d[15:8], 8'h80);
        check("hour reset", d[7:0], 8'h00);
    endtask
    // Slow oscillator keeps beats visible to the detector
    task automatic t_fail();
        rtc_i2c_host_inst.write_regs(8'h01, 16'h0012, 1);
        cyc(2);
        check("flag cleared", {7'h00, fail}, 8'h00);
        osc(504, 150);
        check("flag with beats", {7'h00, fail}, 8'h00);
        cyc(2460);
        check("flag on miss", {7'h00, fail}, 8'h01);
        osc(16, 150);
        rtc_i2c_host_inst.read_regs(8'h01, d);
        check("flag sticky", {7'h00, d[15]}, 8'h01);
    endtask
    // Table: minute in, hour in, minute out, hour out, carries
    task automatic t_count();
        logic [39:0] tbl [6];
        tbl = '{40'h58_09_59_09_00, 40'h59_09_00_10_00,
                40'h0f_00_10_00_00, 40'h79_23_00_00_01,
                40'h6c_00_6d_00_00, 40'h69_05_70_05_00};
        foreach (tbl[i]) begin
            rtc_i2c_host_inst.write_regs(8'h01, tbl[i][39:24], 2);
            carries = 0;
            osc(8, 3);
            cyc(10);
            rtc_i2c_host_inst.read_regs(8'h01, d);
            check("minute", d[15:8] & 8'h7f, tbl[i][23:16]);
            check("hour", d[7:0], tbl[i][15:8]);
            check("day carry", carries[7:0], tbl[i][7:0]);
        end
    endtask
    task automatic t_century(input logic [7:0] h, input logic [7:0] exp);
        rtc_i2c_host_inst.write_regs(8'h02, {8'h00, h}, 1);
        @(posedge clock_i);
        year_wrap_i <= 1'b1;
        @(posedge clock_i);
        year_wrap_i <= 1'b0;
        cyc(3);
        rtc_i2c_host_inst.read_regs(8'h02, d);
        check("century", d[15:8], exp);
    endtask
    task automatic t_stale();
        @(posedge clock_i);
        supply_main_i <= 1'b1;
        cyc(6);
        check("stale on", {7'h00, stale}, 8'h01);
        cyc(40);
        check("stale off", {7'h00, stale}, 8'h00);
    endtask
    // Main sequence; osc domain sees edges while reset is held
    initial begin
        osc(4, 3);
        cyc(3);
        rst_n_i <= 1'b1;
        cyc(5);
        t_reset();
        t_fail();
        t_count();
        t_century(8'h80, 8'hc0);
        t_century(8'h00, 8'h00);
        t_stale();
        check("acks", rtc_i2c_host_inst.nacks[7:0], 8'h00);
        report_and_stop();
    end
    // Watchdog well beyond the expected sixteen thousand cycles
    initial begin
        cyc(100000);
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
